// file: rtl/ecr_defines.vh
// Constants for the E1 common channel signalling timeslot router.
// Assumes inclusion by bare name from the design files only.
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH

// ----------------------------------------------------------------
// Line timeslots carrying common channel signalling
// ----------------------------------------------------------------
`define ECR_SLOT_A        5'h0F
`define ECR_SLOT_B        5'h10
`define ECR_SLOT_C        5'h1F

// ----------------------------------------------------------------
// Backplane rate multipliers and geometry
// ----------------------------------------------------------------
`define ECR_MULT_SLOW     7'h01
`define ECR_MULT_FAST     7'h04
`define ECR_SLOTS_MAX     5'h1F
`define ECR_BYTE_ZERO     8'h00
`define ECR_CHAN_ZERO     7'h00

`endif

// file: rtl/ecr_fifo.v
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module ecr_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage entries
  reg [AW-1:0]    wr_ptr;          // Write index
  reg [AW-1:0]    rd_ptr;          // Read index
  reg [AW:0]      count;           // Occupancy

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];

  // ----------------------------------------------------------------
  // Pointer and count upkeep
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule // ecr_fifo

// file: rtl/ecr_router.v
// E1 common channel signalling router for one framer.
// Assumes backplane bytes arrive already parallel, one strobe per line
// timeslot, on ref_clk; the framer and backplane shifters are outside.
`timescale 1ns/1ps
`include "ecr_defines.vh"

module ecr_router #(
  parameter FIFO_DEPTH = 8
) (
  input  wire       ref_clk,
  input  wire       sys_rst,
  // Configuration levels from control logic (pins)
  input  wire       ccs_mode_select,
  input  wire       slot15_side_copy_en,
  input  wire       slot16_side_copy_en,
  input  wire       slot31_side_copy_en,
  input  wire [4:0] slot15_side_channel_sel,
  input  wire [4:0] slot16_side_channel_sel,
  input  wire [4:0] slot31_side_channel_sel,
  input  wire       fast_rate,
  input  wire [1:0] framer_number,
  // Receive: one line byte per strobe, line bit one in [7]
  input  wire       rx_line_valid,
  input  wire [4:0] rx_line_slot,
  input  wire [7:0] rx_line_byte,
  output reg        rx_line_ready,
  // Backplane data output stream
  output reg        data_out_valid,
  output reg  [6:0] data_out_channel,
  output reg  [7:0] data_out_stream,
  // Backplane signaling output stream
  output reg        signaling_out_valid,
  output reg  [6:0] signaling_out_channel,
  output reg  [7:0] signaling_out_stream,
  input  wire       signaling_out_ready,
  // Transmit: request a byte for a line timeslot
  input  wire       tx_slot_req,
  input  wire [4:0] tx_slot,
  input  wire [7:0] data_in_stream,
  input  wire [7:0] signaling_in_stream,
  output reg  [6:0] tx_data_channel,
  output reg  [6:0] tx_sig_channel,
  output reg        tx_line_valid,
  output reg  [7:0] tx_line_byte
);

  // ----------------------------------------------------------------
  // Input synchronisers for the configuration pins
  // ----------------------------------------------------------------
  reg [18:0] cfg_s1; // First stage, read only by second stage
  reg [18:0] cfg_s2; // Stable configuration
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_s1 <= 19'h00000;
      cfg_s2 <= 19'h00000;
    end else begin
      cfg_s1 <= {ccs_mode_select, slot15_side_copy_en, slot16_side_copy_en,
                 slot31_side_copy_en, slot15_side_channel_sel,
                 slot16_side_channel_sel, slot31_side_channel_sel};
      cfg_s2 <= cfg_s1;
    end
  end

  wire       ccs_on  = cfg_s2[18];
  wire       en15    = cfg_s2[17];
  wire       en16    = cfg_s2[16];
  wire       en31    = cfg_s2[15];
  wire [4:0] sel15   = cfg_s2[14:10];
  wire [4:0] sel16   = cfg_s2[9:5];
  wire [4:0] sel31   = cfg_s2[4:0];
  // Rate and framer are kept apart so a rate change never tears the
  // copy enables and channel fields that share this vector.

  // Rate and framer share a second small synchroniser
  reg [2:0] rate_s1; // First stage
  reg [2:0] rate_s2; // Stable rate and framer number
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rate_s1 <= 3'h0;
      rate_s2 <= 3'h0;
    end else begin
      rate_s1 <= {fast_rate, framer_number};
      rate_s2 <= rate_s1;
    end
  end

  // ----------------------------------------------------------------
  // Channel mapping: channel = n + m*t
  // ----------------------------------------------------------------
  function [6:0] ecr_chan;
    input [4:0] t;
    input       fst;
    input [1:0] fr;
    begin
      if (fst)
        ecr_chan = {t, fr}; // 4*t + framer
      else
        ecr_chan = {2'h0, t}; // m=1, n=0
    end
  endfunction

  // Per-slot lookup of copy enable and side channel
  reg       sig_slot;
  reg       copy_en;
  reg [4:0] side_sel;
  always @* begin
    sig_slot = 1'b1;
    copy_en  = 1'b0;
    side_sel = 5'h00;
    case (rx_line_slot)
      `ECR_SLOT_A: begin
        copy_en  = en15;
        side_sel = sel15;
      end
      `ECR_SLOT_B: begin
        copy_en  = en16;
        side_sel = sel16;
      end
      `ECR_SLOT_C: begin
        copy_en  = en31;
        side_sel = sel31;
      end
      default: sig_slot = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Side copy FIFO: holds channel and byte for the signaling output
  // ----------------------------------------------------------------
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [14:0] fifo_out_data;
  wire        want_copy = rx_line_valid & rx_line_ready & ccs_on &
                          sig_slot & copy_en;
  wire        pop = fifo_out_valid & (~signaling_out_valid |
                                      signaling_out_ready);

  ecr_fifo #(
    .WIDTH (15),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (want_copy),
    .in_ready  (fifo_in_ready),
    .in_data   ({ecr_chan(side_sel, rate_s2[2], rate_s2[1:0]),
                 rx_line_byte}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Receive path; a full FIFO stalls the line side via ready
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_line_ready         <= 1'b0;
      data_out_valid        <= 1'b0;
      data_out_channel      <= `ECR_CHAN_ZERO;
      data_out_stream       <= `ECR_BYTE_ZERO;
      signaling_out_valid   <= 1'b0;
      signaling_out_channel <= `ECR_CHAN_ZERO;
      signaling_out_stream  <= `ECR_BYTE_ZERO;
    end else begin
      // Drop ready for a cycle after each copy push so a byte accepted now always fits
      rx_line_ready  <= fifo_in_ready & ~want_copy;
      data_out_valid <= rx_line_valid & rx_line_ready;
      if (rx_line_valid && rx_line_ready) begin
        // Every slot, including 15/16/31, to its own channel
        data_out_channel <= ecr_chan(rx_line_slot, rate_s2[2],
                                     rate_s2[1:0]);
        // Bit 7 carries line bit one unchanged
        data_out_stream  <= rx_line_byte;
      end
      if (pop) begin
        signaling_out_valid   <= 1'b1;
        signaling_out_channel <= fifo_out_data[14:8];
        signaling_out_stream  <= fifo_out_data[7:0];
      end else if (signaling_out_ready)
        signaling_out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path: channel indices out, chosen byte back next cycle
  // ----------------------------------------------------------------
  reg       tx_t_copy; // Selected slot sources signaling input
  reg [4:0] tx_t_sel;
  always @* begin
    tx_t_copy = 1'b0;
    tx_t_sel  = tx_slot;
    case (tx_slot)
      `ECR_SLOT_A: begin
        tx_t_copy = en15;
        tx_t_sel  = sel15;
      end
      `ECR_SLOT_B: begin
        tx_t_copy = en16;
        tx_t_sel  = sel16;
      end
      `ECR_SLOT_C: begin
        tx_t_copy = en31;
        tx_t_sel  = sel31;
      end
      default: tx_t_copy = 1'b0;
    endcase
  end

  reg tx_pend;      // A request waits for its source bytes
  reg tx_from_sig;  // Byte comes from the signaling input
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_pend         <= 1'b0;
      tx_from_sig     <= 1'b0;
      tx_data_channel <= `ECR_CHAN_ZERO;
      tx_sig_channel  <= `ECR_CHAN_ZERO;
      tx_line_valid   <= 1'b0;
      tx_line_byte    <= `ECR_BYTE_ZERO;
    end else begin
      tx_pend       <= tx_slot_req;
      tx_line_valid <= tx_pend;
      if (tx_slot_req) begin
        // Same-numbered data channel
        tx_data_channel <= ecr_chan(tx_slot, rate_s2[2], rate_s2[1:0]);
        // Chosen signaling channel
        tx_sig_channel  <= ecr_chan(tx_t_sel, rate_s2[2], rate_s2[1:0]);
        tx_from_sig     <= ccs_on & tx_t_copy;
      end
      if (tx_pend)
        tx_line_byte <= tx_from_sig ? signaling_in_stream : data_in_stream;
    end
  end

endmodule // ecr_router

// file: dv/ecr_router_chk.sv
// Port checker for the E1 signalling router.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module ecr_chk (
  input wire       ref_clk,
  input wire       sys_rst,
  input wire       fast_rate,
  input wire [1:0] framer_number,
  input wire       rx_line_valid,
  input wire [4:0] rx_line_slot,
  input wire [7:0] rx_line_byte,
  input wire       rx_line_ready,
  input wire       data_out_valid,
  input wire [6:0] data_out_channel,
  input wire [7:0] data_out_stream,
  input wire       signaling_out_valid,
  input wire [7:0] signaling_out_stream,
  input wire       signaling_out_ready,
  input wire       tx_slot_req,
  input wire [4:0] tx_slot,
  input wire [6:0] tx_data_channel,
  input wire       tx_line_valid
);
  // Backplane channel of a slot; config is held still around traffic
  function [6:0] mp(input [4:0] s);
    mp = fast_rate ? {s, framer_number} : {2'h0, s};
  endfunction
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Receive byte taken, transmit request taken
  sequence s_take;
    rx_line_valid && rx_line_ready;
  endsequence
  sequence s_req;
    tx_slot_req ##1 1'h1;
  endsequence
  property p_dv;
    s_take |=> data_out_valid;
  endproperty
  property p_db;
    s_take |=> data_out_stream == $past(rx_line_byte);
  endproperty
  property p_dc;
    s_take |=> data_out_channel == mp($past(rx_line_slot));
  endproperty
  property p_dp;
    data_out_valid |-> $past(rx_line_valid && rx_line_ready);
  endproperty
  property p_sh;
    signaling_out_valid && !signaling_out_ready
      |=> signaling_out_valid && $stable(signaling_out_stream);
  endproperty
  property p_tv;
    s_req |=> tx_line_valid;
  endproperty
  property p_tc;
    tx_slot_req |=> tx_data_channel == mp($past(tx_slot));
  endproperty
  property p_tp;
    tx_line_valid |-> $past(tx_slot_req, 2);
  endproperty
  a_dv: assert property (p_dv)
    else $error("data out missing");
  a_db: assert property (p_db)
    else $error("data byte bits moved");
  a_dc: assert property (p_dc)
    else $error("data channel wrong");
  a_dp: assert property (p_dp)
    else $error("spurious data out");
  a_sh: assert property (p_sh)
    else $error("signaling out dropped");
  a_tv: assert property (p_tv)
    else $error("transmit byte late");
  a_tc: assert property (p_tc)
    else $error("transmit channel wrong");
  a_tp: assert property (p_tp)
    else $error("spurious transmit byte");
endmodule // ecr_chk

bind ecr_router ecr_chk i_chk (.ref_clk, .sys_rst, .fast_rate,
  .framer_number, .rx_line_valid, .rx_line_slot, .rx_line_byte,
  .rx_line_ready, .data_out_valid, .data_out_channel, .data_out_stream,
  .signaling_out_valid, .signaling_out_stream, .signaling_out_ready,
  .tx_slot_req, .tx_slot, .tx_data_channel, .tx_line_valid);

// file: dv/ecr_bp_model.sv
// Backplane switch model: signaling sink and transmit byte source.
// Assumes channels from the router settle right after each edge.
`timescale 1ns/1ps

module ecr_bp (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       stall,
  input  wire [6:0] tx_data_channel,
  input  wire [6:0] tx_sig_channel,
  output reg        signaling_out_ready,
  output wire [7:0] data_in_stream,
  output wire [7:0] signaling_in_stream
);
  reg [1:0] cnt; // Stall pacing, one accept in four while slow
  // Slow sink lets copies queue in the router FIFO; this bench never fills it
  always @(posedge ref_clk) begin
    cnt <= sys_rst ? 2'h0 : cnt + 2'h1;
    signaling_out_ready <= !stall | (cnt == 2'h3);
  end
  // Each channel holds a distinct byte; the top bit tells the sources
  // apart, so a wrong source pick can never alias a right one
  assign data_in_stream = {1'h0, tx_data_channel} ^ 8'h25;
  assign signaling_in_stream = {1'h1, tx_sig_channel} ^ 8'h3C;
endmodule // ecr_bp

// file: dv/ecr_router_tb.sv
// Self-checking bench for the E1 signalling router.
// Assumes ecr_router, ecr_bp and the bound checker are compiled.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end

module ecr_router_tb;
  reg        ref_clk = 0, sys_rst = 1, ccs = 0, fast = 0, stall = 0;
  reg  [2:0] en = 0;
  reg [14:0] sel = 0;
  reg  [1:0] fr = 0;
  reg        rv = 0, tr = 0;
  reg  [4:0] rs = 0, ts = 0;
  reg  [7:0] rb = 0;
  wire       rx_line_ready, data_out_valid, signaling_out_valid;
  wire       signaling_out_ready, tx_line_valid;
  wire [6:0] data_out_channel, signaling_out_channel;
  wire [6:0] tx_data_channel, tx_sig_channel;
  wire [7:0] data_out_stream, signaling_out_stream, tx_line_byte;
  wire [7:0] data_in_stream, signaling_in_stream;
  int        num_errors = 0, cmp_count = 0, cyc = 0;
  reg [14:0] dq[$], sq[$]; // Expected {channel, byte} per output
  reg  [7:0] tq[$];
  reg  [4:0] sl[3] = '{5'h0F, 5'h10, 5'h1F};
  wire [14:0] do_word = {data_out_channel, data_out_stream};
  wire [14:0] so_word = {signaling_out_channel, signaling_out_stream};

  ecr_router i_dut (.ref_clk, .sys_rst, .ccs_mode_select(ccs),
    .slot15_side_copy_en(en[0]), .slot16_side_copy_en(en[1]),
    .slot31_side_copy_en(en[2]), .slot15_side_channel_sel(sel[4:0]),
    .slot16_side_channel_sel(sel[9:5]), .slot31_side_channel_sel(sel[14:10]),
    .fast_rate(fast), .framer_number(fr), .rx_line_valid(rv),
    .rx_line_slot(rs), .rx_line_byte(rb), .rx_line_ready, .data_out_valid,
    .data_out_channel, .data_out_stream, .signaling_out_valid,
    .signaling_out_channel, .signaling_out_stream, .signaling_out_ready,
    .tx_slot_req(tr), .tx_slot(ts), .data_in_stream, .signaling_in_stream,
    .tx_data_channel, .tx_sig_channel, .tx_line_valid, .tx_line_byte);
  ecr_bp i_bp (.ref_clk, .sys_rst, .stall, .tx_data_channel, .tx_sig_channel,
    .signaling_out_ready, .data_in_stream, .signaling_in_stream);

  always #12.5 ref_clk = ~ref_clk;
  // Backplane channel; index of the copy enable, 3 means none
  function [6:0] mp(input [4:0] s);
    mp = fast ? {s, fr} : {2'h0, s};
  endfunction
  function [1:0] ix(input [4:0] s);
    ix = s == 5'h0F ? 2'h0 : s == 5'h10 ? 2'h1 : s == 5'h1F ? 2'h2 : 2'h3;
  endfunction
  // Drain, then change config; the router lags it by two edges
  task cfg(input c, input f, input [2:0] e);
    rv <= 0;
    tr <= 0;
    while (dq.size() + sq.size() + tq.size() > 0) @(posedge ref_clk);
    ccs <= c;
    fast <= f;
    en <= e;
    fr <= 2'($urandom);
    sel <= 15'($urandom);
    repeat (8) @(posedge ref_clk);
  endtask
  // Offer one line byte, held until an edge sees ready
  task rx(input [4:0] s);
    reg [7:0] b;
    reg [1:0] k;
    b = 8'($urandom);
    k = ix(s);
    rv <= 1;
    rs <= s;
    rb <= b;
    do @(posedge ref_clk); while (rx_line_ready !== 1'b1);
    dq.push_back({mp(s), b});
    if (ccs && k < 3 && en[k]) sq.push_back({mp(sel[k*5 +: 5]), b});
  endtask
  // Request one transmit byte; source follows copy enable
  task tx(input [4:0] s);
    reg [1:0] k;
    k = ix(s);
    // Line side goes idle so no unnoted byte is taken meanwhile
    rv <= 0;
    tr <= 1;
    ts <= s;
    @(posedge ref_clk);
    if (ccs && k < 3 && en[k]) tq.push_back({1'h1, mp(sel[k*5 +: 5])} ^ 8'h3C);
    else tq.push_back({1'h0, mp(s)} ^ 8'h25);
  endtask
  task test_done;
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Output watcher and hang guard
  // ----------------------------------------------------------------
  // Hang guard: running past the ceiling counts as a mismatch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      num_errors++;
      test_done;
    end
  end
  // An output with no note pending is itself a mismatch
  always @(posedge ref_clk) begin
    if (data_out_valid === 1'b1) begin
      `CHK(dq.size() > 0, 1'b1)
      if (dq.size() > 0) `CHK(do_word, dq.pop_front())
    end
    if (signaling_out_valid === 1'b1 && signaling_out_ready === 1'b1) begin
      `CHK(sq.size() > 0, 1'b1)
      if (sq.size() > 0) `CHK(so_word, sq.pop_front())
    end
    if (tx_line_valid === 1'b1) begin
      `CHK(tq.size() > 0, 1'b1)
      if (tq.size() > 0) `CHK(tx_line_byte, tq.pop_front())
    end
  end
  // ----------------------------------------------------------------
  // Every copy-enable mix at both rates; last pass with mode off
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h35BA499C));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 0;
    for (int i = 0; i < 16; i++) begin
      cfg(i != 15, i[3], i[2:0]);
      stall <= i[0];
      for (int j = 0; j < 14; j++) rx(j < 12 ? sl[j % 3] : 5'($urandom));
      for (int j = 0; j < 5; j++) tx(j < 3 ? sl[j] : 5'($urandom));
      $display("Test %0d done", i);
    end
    cfg(1, 0, 3'h0);
    `CHK(dq.size() + sq.size() + tq.size(), 0)
    test_done;
  end
endmodule // ecr_router_tb
